/* File: include/ldo_pkg.sv */
// Package for the regulator mode and fault control block.
// Assumes a 32-bit APB register bus and a 20 MHz system clock.
package ldo_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] VOLT_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h0c;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h10;

  // Control register fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_STBY_BIT = 1;
  localparam int CTRL_SLEEP_BIT = 2;
  localparam int CTRL_LPWR_BIT = 3;
  localparam int CTRL_SHDN_BIT = 4;
  localparam int CTRL_WIDTH = 5;

  // Status register fields
  localparam int STAT_ON_BIT = 0;
  localparam int STAT_LP_BIT = 1;
  localparam int STAT_ILIM_BIT = 2;

  // Interrupt status fields
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_WIDTH = 1;

  // Reset values
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 5'h00;
  localparam logic [3:0] VOLT_RESET = 4'h0;
  localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 1'h1;

  // Voltage table: millivolts at code zero and per step
  localparam logic [11:0] VOLT_BASE_MV = 12'h708;
  localparam logic [11:0] VOLT_STEP_MV = 12'h064;

  // Power-management state codes
  typedef enum logic [1:0] {
    PM_RUN = 2'b00,
    PM_STANDBY = 2'b01,
    PM_SLEEP = 2'b10
  } ldo_pm_state_type;

  // Regulator operating mode
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_ON = 2'b01,
    MODE_LOWPWR = 2'b10
  } ldo_mode_type;

endpackage

/* File: logic/ldo_volt_decode.sv */
// Output voltage code to millivolt decoder.
// Assumes the code comes from a register on the same clock.
`timescale 1ns/1ps
module ldo_volt_decode #(
  parameter int CODE_WIDTH = 4
) (
  input wire logic [CODE_WIDTH-1:0] code,
  output logic [11:0] millivolts
);

  // Linear map from base in fixed steps
  always_comb begin
    millivolts = 12'(ldo_pkg::VOLT_BASE_MV + 12'(code) * ldo_pkg::VOLT_STEP_MV);
  end

endmodule // ldo_volt_decode

/* File: logic/ldo_mode_fault_control.sv */
// Mode and overcurrent fault control for the 400 mA linear regulator.
// Assumes APB on the system clock; overcurrent and power state come from outside and are synchronised.
//
// Functional notes
// - The 4-bit voltage code maps linearly from 1.80 V at 0000 in 0.10 V steps to 3.30 V at 1111.
// - In Run the regulator follows the enable bit alone, ignoring standby, sleep and low-power bits.
// - With enable set, Standby keeps it on only if standby keep-on is 1, Sleep only if sleep keep-on is 1.
// - Low-power operation only in Standby or Sleep, while on there and low-power select is 1.
// - Load current above the limit switches the regulator into current regulation.
// - With shutdown enable set, an overcurrent clears the enable bit and sets the fault flag together.
// - The fault mask bit suppresses the interrupt from the fault flag.
// - With shutdown enable clear, an overload leaves the regulator on in current limit.
// - Shutdown enable resets to 0 so no overload turns the regulator off until software sets it.
// - The fault flag is set on every overload whatever the shutdown enable bit.
`timescale 1ns/1ps
module ldo_mode_fault_control #(
  parameter int CODE_WIDTH = 4
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic overcurrentPin,
  input wire logic [1:0] pmStatePin,
  output logic regulatorOn,
  output logic lowPowerMode,
  output logic currentLimit,
  output logic [CODE_WIDTH-1:0] outputVoltageCode,
  output logic [11:0] outputMillivolts,
  output logic faultIrq
);

  localparam int CTRL_W = ldo_pkg::CTRL_WIDTH;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [CODE_WIDTH-1:0] volt_reg;
  logic [ldo_pkg::IRQ_WIDTH-1:0] irqStatus_reg;
  logic [ldo_pkg::IRQ_WIDTH-1:0] irqMask_reg;
  logic [1:0] ocSync_reg;
  logic [1:0] pmSync1_reg;
  logic [1:0] pmSync2_reg;
  logic [1:0] pmSync3_reg;
  logic [1:0] pmStable_reg;
  logic ocPrev_reg;
  logic [11:0] millivolts;
  logic regulatorEnable;
  logic standbyKeepOn;
  logic sleepKeepOn;
  logic lowPowerSelect;
  logic overcurrentShutdownEnable;
  logic overcurrent;
  logic overcurrentRise;
  logic wrAccess;
  logic rdAccess;
  logic addrOk;
  ldo_pkg::ldo_pm_state_type pmState;
  ldo_pkg::ldo_mode_type mode_next;
  logic [31:0] prdata_next;

  assign regulatorEnable = ctrl_reg[ldo_pkg::CTRL_ENABLE_BIT];
  assign standbyKeepOn = ctrl_reg[ldo_pkg::CTRL_STBY_BIT];
  assign sleepKeepOn = ctrl_reg[ldo_pkg::CTRL_SLEEP_BIT];
  assign lowPowerSelect = ctrl_reg[ldo_pkg::CTRL_LPWR_BIT];
  assign overcurrentShutdownEnable = ctrl_reg[ldo_pkg::CTRL_SHDN_BIT];
  assign overcurrent = ocSync_reg[1];
  assign overcurrentRise = overcurrent && !ocPrev_reg;
  assign pmState = ldo_pkg::ldo_pm_state_type'(pmStable_reg);
  assign wrAccess = psel && penable && pwrite;
  assign rdAccess = psel && !penable && !pwrite;
  assign addrOk = (paddr == ldo_pkg::CTRL_OFFSET) || (paddr == ldo_pkg::VOLT_OFFSET) ||
                  (paddr == ldo_pkg::STATUS_OFFSET) || (paddr == ldo_pkg::IRQ_STATUS_OFFSET) ||
                  (paddr == ldo_pkg::IRQ_MASK_OFFSET);

  // Synchronisers; power state taken once two samples agree
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ocSync_reg <= 2'h0;
      ocPrev_reg <= 1'b0;
      pmSync1_reg <= 2'h0;
      pmSync2_reg <= 2'h0;
      pmSync3_reg <= 2'h0;
      pmStable_reg <= ldo_pkg::PM_RUN;
    end else begin
      ocSync_reg <= {ocSync_reg[0], overcurrentPin};
      ocPrev_reg <= ocSync_reg[1];
      pmSync1_reg <= pmStatePin;
      pmSync2_reg <= pmSync1_reg;
      pmSync3_reg <= pmSync2_reg;
      if (pmSync2_reg == pmSync3_reg) begin
        pmStable_reg <= pmSync2_reg;
      end
    end
  end

  // Control register with automatic shutdown
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_reg <= ldo_pkg::CTRL_RESET;
    end else begin
      if (wrAccess && paddr == ldo_pkg::CTRL_OFFSET) begin
        ctrl_reg <= pwdata[CTRL_W-1:0];
      end
      if (overcurrent && overcurrentShutdownEnable) begin
        ctrl_reg[ldo_pkg::CTRL_ENABLE_BIT] <= 1'b0;
      end
    end
  end

  // Voltage code register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      volt_reg <= CODE_WIDTH'(ldo_pkg::VOLT_RESET);
    end else if (wrAccess && paddr == ldo_pkg::VOLT_OFFSET) begin
      volt_reg <= pwdata[CODE_WIDTH-1:0];
    end
  end

  // Sticky fault flag; a new overload wins over the clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irqStatus_reg <= '0;
    end else begin
      if (wrAccess && paddr == ldo_pkg::IRQ_STATUS_OFFSET) begin
        irqStatus_reg <= irqStatus_reg & ~pwdata[ldo_pkg::IRQ_WIDTH-1:0];
      end
      if (overcurrentRise) begin
        irqStatus_reg[ldo_pkg::IRQ_FAULT_BIT] <= 1'b1;
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irqMask_reg <= ldo_pkg::IRQ_MASK_RESET;
    end else if (wrAccess && paddr == ldo_pkg::IRQ_MASK_OFFSET) begin
      irqMask_reg <= pwdata[ldo_pkg::IRQ_WIDTH-1:0];
    end
  end

  // Operating mode from power state and control bits
  always_comb begin
    mode_next = ldo_pkg::MODE_OFF;
    case (pmState)
      ldo_pkg::PM_RUN: begin
        if (regulatorEnable) begin
          mode_next = ldo_pkg::MODE_ON;
        end
      end
      ldo_pkg::PM_STANDBY: begin
        if (regulatorEnable && standbyKeepOn) begin
          mode_next = lowPowerSelect ? ldo_pkg::MODE_LOWPWR : ldo_pkg::MODE_ON;
        end
      end
      ldo_pkg::PM_SLEEP: begin
        if (regulatorEnable && sleepKeepOn) begin
          mode_next = lowPowerSelect ? ldo_pkg::MODE_LOWPWR : ldo_pkg::MODE_ON;
        end
      end
      default: begin
        mode_next = ldo_pkg::MODE_OFF;
      end
    endcase
  end

  // Regulator outputs
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      regulatorOn <= 1'b0;
      lowPowerMode <= 1'b0;
      currentLimit <= 1'b0;
      outputVoltageCode <= CODE_WIDTH'(ldo_pkg::VOLT_RESET);
      outputMillivolts <= ldo_pkg::VOLT_BASE_MV;
    end else begin
      regulatorOn <= (mode_next != ldo_pkg::MODE_OFF);
      lowPowerMode <= (mode_next == ldo_pkg::MODE_LOWPWR);
      currentLimit <= overcurrent && (mode_next != ldo_pkg::MODE_OFF);
      outputVoltageCode <= volt_reg;
      outputMillivolts <= millivolts;
    end
  end

  ldo_volt_decode #(
    .CODE_WIDTH(CODE_WIDTH)
  ) u_decode (
    .code(volt_reg),
    .millivolts(millivolts)
  );

  // Interrupt output
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      faultIrq <= 1'b0;
    end else begin
      faultIrq <= |(irqStatus_reg & ~irqMask_reg);
    end
  end

  // Read data mux
  always_comb begin
    prdata_next = 32'h0;
    case (paddr)
      ldo_pkg::CTRL_OFFSET: prdata_next[CTRL_W-1:0] = ctrl_reg;
      ldo_pkg::VOLT_OFFSET: prdata_next[CODE_WIDTH-1:0] = volt_reg;
      ldo_pkg::STATUS_OFFSET: begin
        prdata_next[ldo_pkg::STAT_ON_BIT] = regulatorOn;
        prdata_next[ldo_pkg::STAT_LP_BIT] = lowPowerMode;
        prdata_next[ldo_pkg::STAT_ILIM_BIT] = currentLimit;
      end
      ldo_pkg::IRQ_STATUS_OFFSET: prdata_next[ldo_pkg::IRQ_WIDTH-1:0] = irqStatus_reg;
      ldo_pkg::IRQ_MASK_OFFSET: prdata_next[ldo_pkg::IRQ_WIDTH-1:0] = irqMask_reg;
      default: prdata_next = 32'h0;
    endcase
  end

  // APB answer: ready in the first access cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addrOk;
      if (rdAccess) begin
        prdata <= prdata_next;
      end
    end
  end

  // Checks
  sequence overloadSeen_s;
    overcurrent && overcurrentShutdownEnable;
  endsequence

  sequence enableCleared_s;
    !regulatorEnable ##1 !regulatorOn;
  endsequence

  autoShutdown_a: assert property (@(posedge clock) disable iff (sys_rst)
    overloadSeen_s |=> enableCleared_s)
    else $error("enable not cleared after overload shutdown");

  runFollows_a: assert property (@(posedge clock) disable iff (sys_rst)
    (pmState == ldo_pkg::PM_RUN) |=> (regulatorOn == $past(regulatorEnable)))
    else $error("run mode does not follow enable");

  standbyOff_a: assert property (@(posedge clock) disable iff (sys_rst)
    (pmState == ldo_pkg::PM_STANDBY && !standbyKeepOn) |=> !regulatorOn)
    else $error("regulator on in standby without keep-on");

  sleepOff_a: assert property (@(posedge clock) disable iff (sys_rst)
    (pmState == ldo_pkg::PM_SLEEP && !sleepKeepOn) |=> !regulatorOn)
    else $error("regulator on in sleep without keep-on");

  lowPowerOnly_a: assert property (@(posedge clock) disable iff (sys_rst)
    lowPowerMode |-> regulatorOn && $past(pmState != ldo_pkg::PM_RUN && lowPowerSelect))
    else $error("low power outside standby or sleep");

  limitHold_a: assert property (@(posedge clock) disable iff (sys_rst)
    (overcurrent && !overcurrentShutdownEnable && regulatorEnable &&
     pmState == ldo_pkg::PM_RUN) |=> regulatorOn && currentLimit)
    else $error("regulator dropped with shutdown disabled");

  faultFlag_a: assert property (@(posedge clock) disable iff (sys_rst)
    overcurrentRise |=> irqStatus_reg[ldo_pkg::IRQ_FAULT_BIT])
    else $error("fault flag not set on overload");

  flagLatched_a: assert property (@(posedge clock) disable iff (sys_rst)
    irqStatus_reg[ldo_pkg::IRQ_FAULT_BIT] && !(wrAccess && paddr == ldo_pkg::IRQ_STATUS_OFFSET)
    |=> irqStatus_reg[ldo_pkg::IRQ_FAULT_BIT])
    else $error("fault flag lost without clear");

  maskGate_a: assert property (@(posedge clock) disable iff (sys_rst)
    irqMask_reg[ldo_pkg::IRQ_FAULT_BIT] |=> !faultIrq)
    else $error("masked fault raised interrupt");

  voltMap_a: assert property (@(posedge clock) disable iff (sys_rst)
    outputVoltageCode == 4'hf |-> outputMillivolts == 12'hce4)
    else $error("top code not 3.30 V");

  shdnReset_a: assert property (@(posedge clock)
    sys_rst |=> !overcurrentShutdownEnable)
    else $error("shutdown enable not cleared by reset");

  sequence shutdownFlagged_s;
    !regulatorEnable && irqStatus_reg[ldo_pkg::IRQ_FAULT_BIT];
  endsequence

  flagWithShutdown_a: assert property (@(posedge clock) disable iff (sys_rst)
    overcurrentRise && overcurrentShutdownEnable |=> shutdownFlagged_s)
    else $error("shutdown and fault flag not in the same cycle");

  limitCause_a: assert property (@(posedge clock) disable iff (sys_rst)
    currentLimit |-> $past(overcurrent) && regulatorOn)
    else $error("current limit without overload");

  irqRaise_a: assert property (@(posedge clock) disable iff (sys_rst)
    (irqStatus_reg & ~irqMask_reg) != '0 |=> faultIrq)
    else $error("unmasked fault did not raise interrupt");

  pmSteady_a: assert property (@(posedge clock) disable iff (sys_rst)
    $changed(pmStable_reg) |-> $past(pmSync2_reg == pmSync3_reg))
    else $error("power state taken before two samples agreed");

endmodule // ldo_mode_fault_control

/* File: sim/ldo_host_model.sv */
// Host side model: APB master as seen from the regulator control block.
// Assumes one clock; tasks are called by the bench and return after the answer.
`timescale 1ns/1ps
module ldo_host_model (
  input wire logic clock,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // One transfer: setup, access held until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule // ldo_host_model

/* File: sim/ldo_mode_fault_control_tb_top.sv */
// Self-checking bench for the regulator mode and fault control block.
// Assumes the host model for APB traffic and a 20 MHz clock.
`timescale 1ns/1ps
module ldo_mode_fault_control_tb_top;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdVal;
  logic errFlag;
  logic overcurrentPin = 1'b0;
  logic [1:0] pmStatePin = 2'b00;
  logic regulatorOn, lowPowerMode, currentLimit, faultIrq;
  logic [3:0] outputVoltageCode;
  logic [11:0] outputMillivolts;
  int errCount = 0;
  int checkCount = 0;

  always #25 clock = ~clock;

  ldo_host_model hostModel (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  ldo_mode_fault_control dut_u (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .overcurrentPin(overcurrentPin), .pmStatePin(pmStatePin),
    .regulatorOn(regulatorOn), .lowPowerMode(lowPowerMode), .currentLimit(currentLimit),
    .outputVoltageCode(outputVoltageCode), .outputMillivolts(outputMillivolts), .faultIrq(faultIrq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    hostModel.xfer(1'b1, a, d, rdVal, errFlag);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    hostModel.xfer(1'b0, a, 32'h0, rdVal, errFlag);
    chk(rdVal, exp);
  endtask

  task automatic waitCy(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic printVerdict();
    if (errCount == 0 && checkCount > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic testVoltage();
    for (int c = 0; c < 16; c++) begin
      wr(ldo_pkg::VOLT_OFFSET, 32'(c));
      waitCy(3);
      chk(32'(outputMillivolts), 32'(ldo_pkg::VOLT_BASE_MV) + 32'(ldo_pkg::VOLT_STEP_MV) * 32'(c));
      chk(32'(outputVoltageCode), 32'(c));
    end
    rdChk(ldo_pkg::VOLT_OFFSET, 32'hf);
  endtask

  task automatic testModes();
    logic on, lp;
    for (int s = 0; s < 3; s++) begin
      @(posedge clock);
      pmStatePin <= 2'(s);
      for (int c = 0; c < 16; c++) begin
        wr(ldo_pkg::CTRL_OFFSET, 32'(c));
        waitCy(4);
        on = c[0] && (s == 0 || (s == 1 && c[1]) || (s == 2 && c[2]));
        lp = on && s != 0 && c[3];
        chk(32'(regulatorOn), 32'(on));
        chk(32'(lowPowerMode), 32'(lp));
      end
    end
    @(posedge clock);
    pmStatePin <= 2'b00;
  endtask

  task automatic testLimit();
    wr(ldo_pkg::CTRL_OFFSET, 32'h1);
    @(posedge clock);
    overcurrentPin <= 1'b1;
    waitCy(5);
    chk(32'(currentLimit), 32'h1);
    chk(32'(regulatorOn), 32'h1);
    rdChk(ldo_pkg::STATUS_OFFSET, 32'h5);
    rdChk(ldo_pkg::IRQ_STATUS_OFFSET, 32'h1);
    chk(32'(faultIrq), 32'h0);
    wr(ldo_pkg::IRQ_MASK_OFFSET, 32'h0);
    waitCy(2);
    chk(32'(faultIrq), 32'h1);
    wr(ldo_pkg::IRQ_STATUS_OFFSET, 32'h1);
    waitCy(2);
    chk(32'(faultIrq), 32'h0);
    @(posedge clock);
    overcurrentPin <= 1'b0;
    waitCy(4);
  endtask

  task automatic testShutdown();
    wr(ldo_pkg::CTRL_OFFSET, 32'h11);
    @(posedge clock);
    overcurrentPin <= 1'b1;
    waitCy(5);
    rdChk(ldo_pkg::CTRL_OFFSET, 32'h10);
    chk(32'(regulatorOn), 32'h0);
    rdChk(ldo_pkg::STATUS_OFFSET, 32'h0);
    rdChk(ldo_pkg::IRQ_STATUS_OFFSET, 32'h1);
    @(posedge clock);
    overcurrentPin <= 1'b0;
    waitCy(4);
    chk(32'(faultIrq), 32'h1);
    wr(ldo_pkg::IRQ_STATUS_OFFSET, 32'h1);
    wr(ldo_pkg::CTRL_OFFSET, 32'h11);
    waitCy(3);
    chk(32'(faultIrq), 32'h0);
    chk(32'(regulatorOn), 32'h1);
  endtask

  task automatic testReset(input logic midRun);
    if (midRun) begin
      @(posedge clock);
      sys_rst <= 1'b1;
    end
    waitCy(10);
    sys_rst <= 1'b0;
    waitCy(1);
    chk(32'(outputMillivolts), 32'(ldo_pkg::VOLT_BASE_MV));
    chk(32'(regulatorOn), 32'h0);
    chk(32'(faultIrq), 32'h0);
    rdChk(ldo_pkg::CTRL_OFFSET, 32'h0);
    chk(32'(errFlag), 32'h0);
    rdChk(ldo_pkg::IRQ_MASK_OFFSET, 32'h1);
    rdChk(8'h20, 32'h0);
    chk(32'(errFlag), 32'h1);
  endtask

  initial begin
    testReset(1'b0);
    testVoltage();
    testModes();
    testLimit();
    testShutdown();
    testReset(1'b1);
    printVerdict();
  end

  initial begin
    waitCy(20000);
    errCount++;
    printVerdict();
  end
endmodule // ldo_mode_fault_control_tb_top
